// ===== hw/csf_pkg.sv
// Package of the status-flag unit: flags register layout, offsets, op codes.
// Assumes a single 100 MHz clock domain and an Avalon-MM register slave.
package csf_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] FLAGS_OFS = 8'hd5;
	localparam logic [7:0] CTRL_OFS = 8'hd6;
	localparam logic [7:0] OPER_OFS = 8'hd7;
	localparam logic [7:0] RESULT_OFS = 8'hd8;
	localparam logic [7:0] ADDR_OFS = 8'hd9;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
	// ****************************************
	// Flag positions
	// ****************************************
	localparam int C_POS = 7;
	localparam int Z_POS = 6;
	localparam int S_POS = 5;
	localparam int V_POS = 4;
	localparam int D_POS = 3;
	localparam int H_POS = 2;
	localparam int FIS_POS = 1;
	localparam int BA_POS = 0;
	// ****************************************
	// Operations
	// ****************************************
	typedef enum logic [4:0] {
		CSF_NOP = 5'h00, CSF_ADD = 5'h01, CSF_ADC = 5'h02, CSF_SUB = 5'h03,
		CSF_SBC = 5'h04, CSF_AND = 5'h05, CSF_OR = 5'h06, CSF_XOR = 5'h07,
		CSF_RL = 5'h08, CSF_RLC = 5'h09, CSF_RR = 5'h0a, CSF_RRC = 5'h0b,
		CSF_SRA = 5'h0c, CSF_BTST = 5'h0d, CSF_SCF = 5'h0e, CSF_RCF = 5'h0f,
		CSF_CCF = 5'h10, CSF_DA = 5'h11, CSF_SB0 = 5'h12, CSF_SB1 = 5'h13,
		CSF_FIRQ = 5'h14, CSF_INTERRUPT_RETURN_INSTR = 5'h15, CSF_JCC = 5'h16, CSF_REL = 5'h17,
		CSF_XSHORT = 5'h18, CSF_XLONG = 5'h19, CSF_CP = 5'h1a
	} csf_op_t;
	localparam logic [3:0] CC_NEVER = 4'h0;
	localparam logic [3:0] CC_ALWAYS = 4'h8;
	localparam logic [7:0] BCD_LO_ADJ = 8'h06;
	localparam logic [7:0] BCD_HI_ADJ = 8'h60;
endpackage

// ===== hw/csf_bank_regs.sv
// Small register memory of the two set 1 banks, selected by the bank bit.
// Assumes one clock and a synchronous write; read data come from a register.
`timescale 1ns/1ns
`default_nettype none
module csf_bank_regs #(
	parameter int AW = 4
) (
	input wire logic clock,
	input wire logic bank,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(2**(AW+1))-1];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[{bank, addr}] <= wdata;
		end
		rdata <= mem[{bank, addr}];
	end
endmodule
`default_nettype wire

// ===== hw/csf_flags_unit.sv
// Status-flag unit of an 8-bit CPU core with its operand-range helpers.
// Assumes an Avalon-MM master; operations are issued by writing the control register.
// Contract
// - Carry set on carry out of or borrow into bit 7.
// - Shifts and rotates load carry with last bit shifted out.
// - Instructions set, clear or complement the carry.
// - Arithmetic and logic set zero when the full result is zero.
// - Bit tests, shifts and rotates set zero when result is zero.
// - Sign copies the result most significant bit.
// - Overflow set when signed result leaves minus 128 to 127.
// - Logic operations clear overflow.
// - Decimal bit records add or subtract; never a jump condition.
// - Half carry on carry from bit 3 or borrow from bit 4.
// - Decimal adjust uses half carry and decimal bit for BCD.
// - Fast interrupt bit set on entry, cleared by interrupt return.
// - Fast interrupt bit blocks interrupts; return takes fast path.
// - Bank bit chooses set 1 bank; low clears, high sets.
// - Working registers 0 to 15, bits 0 to 7.
// - Register pairs use even addresses only.
// - Relative target is next address plus signed 8-bit offset.
// - Short index adds signed offset; long index adds unsigned 16 bits.
// - Immediates are 8-bit or 16-bit values.
// - Flag op writing the flags register gives undefined outcome.
// - Four-bit condition field tests carry, zero, sign, overflow.
`timescale 1ns/1ns
`default_nettype none
module csf_flags_unit (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq_block,
	output logic fast_return,
	output logic jump_taken,
	output logic [7:0] bank_rdata
);
	// ****************************************
	// Reset synchroniser
	// ****************************************
	logic rst_s1_r, rst_n_r;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Control word: [4:0] operation, [11:8] condition field, [15:12] register number,
	// [18:16] bit number.  Operand word: [7:0] a, [15:8] b, [31:16] base/long value.
	logic [7:0] flags_r;
	logic [31:0] ctrl_r, oper_r;
	logic [7:0] result_r;
	logic [15:0] addr_r;
	logic go_r;
	logic ack_r;

	csf_pkg::csf_op_t op;
	logic [7:0] a, b;
	logic [15:0] wide;
	logic [3:0] cc;
	assign op = csf_pkg::csf_op_t'(ctrl_r[4:0]);
	assign a = oper_r[7:0];
	assign b = oper_r[15:8];
	assign wide = oper_r[31:16];
	assign cc = ctrl_r[11:8];

	logic wr_hit, rd_req;
	// A write lands only at the edge where waitrequest is low.
	assign wr_hit = avs_write && ack_r;
	assign rd_req = avs_read && !ack_r;

	// ****************************************
	// Bus slave: every access takes one wait cycle
	// ****************************************
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			avs_readdata <= csf_pkg::UNMAPPED_RD;
		end else if (rd_req) begin
			case (avs_address)
				csf_pkg::FLAGS_OFS: avs_readdata <= {24'h000000, flags_r};
				csf_pkg::CTRL_OFS: avs_readdata <= ctrl_r;
				csf_pkg::OPER_OFS: avs_readdata <= oper_r;
				csf_pkg::RESULT_OFS: avs_readdata <= {24'h000000, result_r};
				csf_pkg::ADDR_OFS: avs_readdata <= {16'h0000, addr_r};
				default: avs_readdata <= csf_pkg::UNMAPPED_RD;
			endcase
		end
	end

	always_comb begin
		avs_waitrequest = (avs_read || avs_write) && !ack_r;
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= 32'h0000_0000;
			oper_r <= 32'h0000_0000;
			go_r <= 1'b0;
		end else begin
			go_r <= 1'b0;
			if (wr_hit && avs_address == csf_pkg::CTRL_OFS) begin
				ctrl_r <= merge(ctrl_r, avs_writedata, avs_byteenable);
				go_r <= avs_byteenable[0];
			end
			if (wr_hit && avs_address == csf_pkg::OPER_OFS) begin
				oper_r <= merge(oper_r, avs_writedata, avs_byteenable);
			end
		end
	end

	// ****************************************
	// Arithmetic and flag computation
	// ****************************************
	logic [8:0] sum9;
	logic [4:0] nib;
	logic [7:0] res, da_adj, nf;
	logic cin, is_sub, is_arith, is_logic, is_shift, cond;

	always_comb begin
		nf = flags_r;
		res = 8'h00;
		sum9 = 9'h000;
		nib = 5'h00;
		da_adj = 8'h00;
		cin = (op == csf_pkg::CSF_ADC || op == csf_pkg::CSF_SBC) ? flags_r[csf_pkg::C_POS] : 1'b0;
		is_sub = op == csf_pkg::CSF_SUB || op == csf_pkg::CSF_SBC || op == csf_pkg::CSF_CP;
		is_arith = is_sub || op == csf_pkg::CSF_ADD || op == csf_pkg::CSF_ADC;
		is_logic = op == csf_pkg::CSF_AND || op == csf_pkg::CSF_OR || op == csf_pkg::CSF_XOR;
		is_shift = op == csf_pkg::CSF_RL || op == csf_pkg::CSF_RLC || op == csf_pkg::CSF_RR ||
			op == csf_pkg::CSF_RRC || op == csf_pkg::CSF_SRA;
		if (is_arith) begin
			if (is_sub) begin
				sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			end else begin
				sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
				nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			end
			res = sum9[7:0];
			nf[csf_pkg::C_POS] = sum9[8];
			nf[csf_pkg::V_POS] = is_sub ? (a[7] != b[7]) && (res[7] != a[7])
				: (a[7] == b[7]) && (res[7] != a[7]);
			if (op != csf_pkg::CSF_CP) begin
				nf[csf_pkg::D_POS] = is_sub;
				nf[csf_pkg::H_POS] = nib[4];
			end
		end
		case (op)
			csf_pkg::CSF_AND: res = a & b;
			csf_pkg::CSF_OR: res = a | b;
			csf_pkg::CSF_XOR: res = a ^ b;
			csf_pkg::CSF_RL: res = {a[6:0], a[7]};
			csf_pkg::CSF_RLC: res = {a[6:0], flags_r[csf_pkg::C_POS]};
			csf_pkg::CSF_RR: res = {a[0], a[7:1]};
			csf_pkg::CSF_RRC: res = {flags_r[csf_pkg::C_POS], a[7:1]};
			csf_pkg::CSF_SRA: res = {a[7], a[7:1]};
			csf_pkg::CSF_BTST: res = {7'h00, a[ctrl_r[18:16]]};
			csf_pkg::CSF_DA: begin
				if (flags_r[csf_pkg::H_POS] || (!flags_r[csf_pkg::D_POS] && a[3:0] > 4'h9)) begin
					da_adj = da_adj | csf_pkg::BCD_LO_ADJ;
				end
				if (flags_r[csf_pkg::C_POS] || (!flags_r[csf_pkg::D_POS] && a > 8'h99)) begin
					da_adj = da_adj | csf_pkg::BCD_HI_ADJ;
				end
				res = flags_r[csf_pkg::D_POS] ? a - da_adj : a + da_adj;
				nf[csf_pkg::C_POS] = flags_r[csf_pkg::C_POS] || da_adj[6] && !flags_r[csf_pkg::D_POS];
				nf[csf_pkg::Z_POS] = res == 8'h00;
				nf[csf_pkg::S_POS] = res[7];
			end
			default: begin
			end
		endcase
		if (is_logic) begin
			nf[csf_pkg::V_POS] = 1'b0;
		end
		if (is_shift) begin
			nf[csf_pkg::C_POS] = (op == csf_pkg::CSF_RL || op == csf_pkg::CSF_RLC) ? a[7] : a[0];
			nf[csf_pkg::V_POS] = res[7] != a[7];
		end
		if (is_arith || is_logic) begin
			nf[csf_pkg::Z_POS] = res == 8'h00;
		end
		if (is_shift || op == csf_pkg::CSF_BTST) begin
			nf[csf_pkg::Z_POS] = res == 8'h00;
		end
		if (is_arith || is_logic || is_shift) begin
			nf[csf_pkg::S_POS] = res[7];
		end
		case (op)
			csf_pkg::CSF_SCF: nf[csf_pkg::C_POS] = 1'b1;
			csf_pkg::CSF_RCF: nf[csf_pkg::C_POS] = 1'b0;
			csf_pkg::CSF_CCF: nf[csf_pkg::C_POS] = !flags_r[csf_pkg::C_POS];
			csf_pkg::CSF_SB0: nf[csf_pkg::BA_POS] = 1'b0;
			csf_pkg::CSF_SB1: nf[csf_pkg::BA_POS] = 1'b1;
			csf_pkg::CSF_FIRQ: nf[csf_pkg::FIS_POS] = 1'b1;
			csf_pkg::CSF_INTERRUPT_RETURN_INSTR: nf[csf_pkg::FIS_POS] = 1'b0;
			default: begin
			end
		endcase
	end

	// Only carry, zero, sign and overflow feed the condition; decimal is never tested.
	always_comb begin
		case (cc[2:0])
			3'h0: cond = 1'b0;
			3'h1: cond = flags_r[csf_pkg::S_POS] ^ flags_r[csf_pkg::V_POS];
			3'h2: cond = flags_r[csf_pkg::Z_POS] ||
				(flags_r[csf_pkg::S_POS] ^ flags_r[csf_pkg::V_POS]);
			3'h3: cond = !flags_r[csf_pkg::C_POS] && 1'b0 || flags_r[csf_pkg::C_POS] ||
				flags_r[csf_pkg::Z_POS];
			3'h4: cond = flags_r[csf_pkg::V_POS];
			3'h5: cond = flags_r[csf_pkg::S_POS];
			3'h6: cond = flags_r[csf_pkg::Z_POS];
			3'h7: cond = flags_r[csf_pkg::C_POS];
			default: cond = 1'b0;
		endcase
	end

	// ****************************************
	// Flags register
	// ****************************************
	// A software write of the flags register in the same cycle as an operation is
	// resolved in favour of the operation; the outcome is otherwise undefined.
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			flags_r <= csf_pkg::FLAGS_RST;
		end else if (go_r) begin
			flags_r <= nf;
		end else if (wr_hit && avs_address == csf_pkg::FLAGS_OFS && avs_byteenable[0]) begin
			flags_r <= avs_writedata[7:0];
		end
	end

	// ****************************************
	// Results and address forming
	// ****************************************
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			result_r <= 8'h00;
			addr_r <= 16'h0000;
			jump_taken <= 1'b0;
			fast_return <= 1'b0;
		end else begin
			fast_return <= 1'b0;
			if (go_r) begin
				result_r <= res;
				case (op)
					csf_pkg::CSF_JCC: jump_taken <= cc[3] ? !cond : cond;
					csf_pkg::CSF_REL: addr_r <= wide + {{8{a[7]}}, a};
					csf_pkg::CSF_XSHORT: addr_r <= {wide[15:1], 1'b0} + {{8{a[7]}}, a};
					csf_pkg::CSF_XLONG: addr_r <= {8'h00, a[3:1], 1'b0} + wide;
					csf_pkg::CSF_INTERRUPT_RETURN_INSTR: fast_return <= flags_r[csf_pkg::FIS_POS];
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_block <= 1'b0;
		end else begin
			irq_block <= flags_r[csf_pkg::FIS_POS];
		end
	end

	// ****************************************
	// Set 1 bank storage
	// ****************************************
	logic bank_we;
	assign bank_we = wr_hit && avs_address[7:4] == 4'he;
	csf_bank_regs #(.AW(4)) u_bank (
		.clock(clock),
		.bank(flags_r[csf_pkg::BA_POS]),
		.we(bank_we),
		.addr(avs_address[3:0]),
		.wdata(avs_writedata[7:0]),
		.rdata(bank_rdata)
	);
endmodule
`default_nettype wire

// ===== test/csf_flags_unit_chk.sv
// Checker of the status-flag unit, watching only the top module ports.
// Assumes one clock domain and a master that holds each request until acked.
`timescale 1ns/1ns
`default_nettype none
module csf_flags_unit_chk (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic irq_block,
	input wire logic fast_return,
	input wire logic jump_taken
);
	// ****************************************
	// Sequences
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	logic req;
	assign req = avs_read | avs_write;
	sequence s_fast_exit;
		fast_return ##1 !fast_return ##[0:1] !irq_block;
	endsequence
	sequence s_wr_recent;
		$past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	idle_no_wait_a: assert property (!req |-> !avs_waitrequest)
		else $error("waitrequest high while idle");
	first_wait_a: assert property ($rose(req) |-> avs_waitrequest)
		else $error("no wait cycle on new request");
	answer_bound_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait");
	wait_once_a: assert property (req && !avs_waitrequest |-> $past(avs_waitrequest))
		else $error("request answered without wait cycle");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without a read");
	ret_pulse_a: assert property (fast_return |-> s_fast_exit)
		else $error("fast return not a pulse clearing the block");
	ret_cause_a: assert property ($rose(fast_return) |-> s_wr_recent)
		else $error("fast return without an issued operation");
	jump_cause_a: assert property ($changed(jump_taken) |-> s_wr_recent)
		else $error("jump result moved without an operation");
	irq_cause_a: assert property ($changed(irq_block) |-> s_wr_recent)
		else $error("interrupt block moved without a write");
endmodule
bind csf_flags_unit csf_flags_unit_chk u_chk (.clock(clock), .arst_n(arst_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.avs_readdata(avs_readdata), .irq_block(irq_block), .fast_return(fast_return),
	.jump_taken(jump_taken));
`default_nettype wire

// ===== test/csf_flags_unit_tb_top.sv
// Self-checking bench of the status-flag unit through its Avalon-MM slave.
// Assumes the design package and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module csf_flags_unit_tb_top;
	typedef struct {string nm; logic [31:0] exp; logic [31:0] msk; int src;} csf_note_t;
	logic clock, arst_n, avs_read, avs_write, avs_waitrequest, irq_block, fast_return;
	logic jump_taken, probe, fr_seen;
	logic [7:0] avs_address, bank_rdata, f, a, b;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [15:0] mf;
	int errors, samples_checked, seed;
	csf_note_t notes[$];
	csf_flags_unit uut (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq_block(irq_block),
		.fast_return(fast_return), .jump_taken(jump_taken), .bank_rdata(bank_rdata));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ****************************************
	// Scoreboard
	// ****************************************
	initial fr_seen = 1'b0;
	always @(posedge clock) begin
		if (fast_return === 1'b1) begin
			fr_seen <= 1'b1;
		end
	end
	always @(negedge clock) begin
		csf_note_t n;
		logic [31:0] seen;
		if ((avs_read && avs_waitrequest === 1'b0) || probe) begin
			n = notes.pop_front();
			seen = (n.src == 1) ? {31'h0, jump_taken} : (n.src == 2) ? {31'h0, irq_block} :
				(n.src == 3) ? {24'h0, bank_rdata} : (n.src == 4) ? {31'h0, fr_seen} :
				avs_readdata;
			samples_checked++;
			if ((seen & n.msk) !== (n.exp & n.msk)) begin
				errors++;
				$display("BAD %s exp %h seen %h", n.nm, n.exp & n.msk, seen & n.msk);
			end
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		logic w8;
		n = 0;
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(negedge clock);
			w8 = avs_waitrequest;
			@(posedge clock);
			n++;
		end while (w8 !== 1'b0 && n < 100);
		if (n == 100) errors++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e, m, input string nm);
		notes.push_back('{nm, e, m, 0});
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic pt(input int s, input logic [31:0] e, input string nm);
		repeat (3) @(posedge clock);
		notes.push_back('{nm, e, 32'hffffffff, s});
		probe <= 1'b1;
		@(posedge clock);
		probe <= 1'b0;
	endtask
	task automatic op(input logic [4:0] o, input logic [3:0] cc);
		bus(1'b1, csf_pkg::CTRL_OFS, {20'h0, cc, 3'h0, o});
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Returns the compared-bit mask above the expected flags.
	function automatic logic [15:0] model(input logic [4:0] o, input logic [7:0] a, b, f);
		logic [8:0] r;
		logic [4:0] h;
		logic [7:0] m;
		logic ci, sub, v;
		ci = (o == csf_pkg::CSF_ADC || o == csf_pkg::CSF_SBC) & f[7];
		sub = (o == csf_pkg::CSF_SUB || o == csf_pkg::CSF_SBC);
		r = sub ? a - b - ci : a + b + ci;
		h = sub ? a[3:0] - b[3:0] - ci : a[3:0] + b[3:0] + ci;
		v = ((a[7] ^ b[7]) == sub) & (r[7] ^ a[7]);
		m = 8'hf4;
		case (o)
			csf_pkg::CSF_AND: r = {f[7], a & b};
			csf_pkg::CSF_OR: r = {f[7], a | b};
			csf_pkg::CSF_XOR: r = {f[7], a ^ b};
			csf_pkg::CSF_RL: r = {a[7], a[6:0], a[7]};
			csf_pkg::CSF_RLC: r = {a, f[7]};
			csf_pkg::CSF_RR: r = {a[0], a[0], a[7:1]};
			csf_pkg::CSF_RRC: r = {a[0], f[7], a[7:1]};
			csf_pkg::CSF_SRA: r = {a[0], a[7], a[7:1]};
			csf_pkg::CSF_SCF: r = 9'h100;
			csf_pkg::CSF_RCF: r = 9'h000;
			csf_pkg::CSF_CCF: r = {~f[7], 8'h0};
			default: r = r;
		endcase
		if (o >= csf_pkg::CSF_AND) v = 1'b0;
		if (o >= csf_pkg::CSF_AND) m = (o < csf_pkg::CSF_RL) ? 8'h70 : 8'he0;
		if (o >= csf_pkg::CSF_SCF) m = (o < csf_pkg::CSF_SB0) ? 8'h80 : (o < 5'h14) ? 8'h01 : 8'h02;
		return {m, r[8], r[7:0] == 8'h0, r[7], v, f[3], h[4], o == csf_pkg::CSF_FIRQ,
			o == csf_pkg::CSF_SB1};
	endfunction
	function automatic logic cond(input logic [3:0] cc, input logic [7:0] f);
		logic [7:0] t;
		t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
		return t[cc[2:0]] ^ cc[3];
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'hec43b1d0;
		{arst_n, avs_read, avs_write, probe, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rd(csf_pkg::FLAGS_OFS, {24'h0, csf_pkg::FLAGS_RST}, 32'hff, "flags_rst");
		rd(8'h10, csf_pkg::UNMAPPED_RD, 32'hffffffff, "unmapped");
		bus(1'b1, csf_pkg::FLAGS_OFS, 32'h5a);
		rd(csf_pkg::FLAGS_OFS, 32'h5a, 32'hff, "flags_rw");
		for (int i = 1; i < 22; i++) begin
			if (i == 13 || i == 17) continue;
			for (int k = 0; k < 4; k++) begin
				f = 8'($random(seed));
				a = (k == 0) ? 8'h7f : (k == 1) ? 8'h80 : 8'($random(seed));
				b = (k == 0) ? 8'h01 : (k == 1) ? 8'h80 : 8'($random(seed));
				bus(1'b1, csf_pkg::FLAGS_OFS, {24'h0, f});
				bus(1'b1, csf_pkg::OPER_OFS, {16'h0, b, a});
				op(i[4:0], 4'h0);
				mf = model(i[4:0], a, b, f);
				rd(csf_pkg::FLAGS_OFS, {24'h0, mf[7:0]}, {24'h0, mf[15:8]}, "flags");
			end
		end
		for (int c = 0; c < 16; c++) begin
			f = 8'($random(seed));
			bus(1'b1, csf_pkg::FLAGS_OFS, {24'h0, f});
			op(csf_pkg::CSF_JCC, c[3:0]);
			pt(1, {31'h0, cond(c[3:0], f)}, "jump_taken");
		end
		bus(1'b1, csf_pkg::FLAGS_OFS, 32'h0);
		op(csf_pkg::CSF_FIRQ, 4'h0);
		pt(2, 32'h1, "irq_block_set");
		op(csf_pkg::CSF_INTERRUPT_RETURN_INSTR, 4'h0);
		pt(2, 32'h0, "irq_block_clr");
		pt(4, 32'h1, "fast_return");
		a = 8'($random(seed));
		b = ~a;
		op(csf_pkg::CSF_SB1, 4'h0);
		bus(1'b1, 8'he3, {24'h0, a});
		op(csf_pkg::CSF_SB0, 4'h0);
		bus(1'b1, 8'he3, {24'h0, b});
		pt(3, {24'h0, b}, "bank_low");
		op(csf_pkg::CSF_SB1, 4'h0);
		rd(8'he3, csf_pkg::UNMAPPED_RD, 32'hffffffff, "bank_addr");
		pt(3, {24'h0, a}, "bank_high");
		repeat (4) @(posedge clock);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
